// >>> nvc_host.sv
// host controller driving the shadowed sram pins
`timescale 1ns/100ps
// Operation
// - host holds address through write and keeps output drive high
// - store trigger is six select-timed reads in fixed order
// - recall trigger ends with 0x0F0E instead of store address
// - host uses reads only; output drive optional for trigger
// - system keeps strobe or select inactive at power-up recall end
// - write strobe high during all six trigger cycles
module nvc_host
  import nvc_pkg::*;
#(
  parameter int STORE_CYCLES   = STORE_CYC,
  parameter int RESTORE_CYCLES = RESTORE_CYC,
  parameter int PWRUP_CYCLES   = PWRUP_CYC
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              reqValid,
  input  wire logic [1:0]        reqCmd,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqWdata,
  output logic                   reqReady,
  output logic                   rspValid,
  output logic      [DATA_W-1:0] rspRdata,
  output logic                   ceN,
  output logic                   weN,
  output logic                   oeN,
  output logic      [ADDR_W-1:0] addrLines,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic                   dataOeN
);
  nvc_state_t        state_ff, nxt_state;
  logic [CNT_W-1:0]  cnt_ff;
  logic [2:0]        seqIdx_ff;
  logic              seqMode_ff;
  logic              isWrite_ff;
  logic              isSeq_ff;
  logic [CNT_W-1:0]  waitCyc_ff;
  logic [ADDR_W-1:0] seqAddr;

  wire isNvCmd   = reqCmd[1];
  wire takeReq   = reqValid && reqReady;
  wire cntDone   = (cnt_ff == '0);
  wire seqLast   = (seqIdx_ff == 3'(SEQ_LEN - 1));
  wire [CNT_W-1:0] accCnt = CNT_W'(ACCESS_CYC - 1);
  // table is addressed with the coming index so its registered word is ready in setup
  wire [2:0] nxt_seqIdx = (state_ff == NVC_IDLE && takeReq) ? 3'h0
                        : (state_ff == NVC_END && isSeq_ff && !seqLast) ? seqIdx_ff + 3'h1
                        : seqIdx_ff;
  wire nxt_seqMode = (state_ff == NVC_IDLE && takeReq) ? (reqCmd == CMD_RECALL) : seqMode_ff;
  // first cycle after reset only arms the power-up counter
  wire pwrFirst = (state_ff == NVC_PWR) && (waitCyc_ff == '0);

  nvc_seq_rom nvc_seq_rom_inst (
    .clk     (clk),
    .resetn  (resetn),
    .idx     (nxt_seqIdx),
    .recall  (nxt_seqMode),
    .addrOut (seqAddr)
  );

  // next-state decode
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      NVC_PWR:   if (cntDone && !pwrFirst) nxt_state = NVC_IDLE;
      NVC_IDLE:  if (takeReq) nxt_state = NVC_SETUP;
      NVC_SETUP: nxt_state = NVC_ACT;
      NVC_ACT:   if (cntDone) nxt_state = NVC_END;
      NVC_END: begin
        if (isSeq_ff && !seqLast) nxt_state = NVC_SETUP; // back to back reads
        else if (isSeq_ff) nxt_state = NVC_WAIT;
        else nxt_state = NVC_IDLE;
      end
      NVC_WAIT:  if (cntDone) nxt_state = NVC_IDLE;
      default:   nxt_state = NVC_IDLE;
    endcase
  end

  // state and counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff   <= NVC_PWR;
      cnt_ff     <= '0;
      seqIdx_ff  <= '0;
      seqMode_ff <= 1'b0;
      isWrite_ff <= 1'b0;
      isSeq_ff   <= 1'b0;
      waitCyc_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == NVC_PWR && cnt_ff == '0 && waitCyc_ff == '0) begin
        // first cycle: load power-up recall wait
        cnt_ff     <= CNT_W'(PWRUP_CYCLES);
        waitCyc_ff <= CNT_W'(1);
      end else if (!cntDone) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
      if (state_ff == NVC_IDLE && takeReq) begin
        isWrite_ff <= (reqCmd == CMD_WRITE);
        isSeq_ff   <= isNvCmd;
        waitCyc_ff <= (reqCmd == CMD_RECALL) ? CNT_W'(RESTORE_CYCLES)
                                             : CNT_W'(STORE_CYCLES);
      end
      if (state_ff == NVC_SETUP) cnt_ff <= accCnt;
      seqIdx_ff  <= nxt_seqIdx; // no other access interleaves
      seqMode_ff <= nxt_seqMode;
      if (state_ff == NVC_END && isSeq_ff && seqLast)
        cnt_ff <= waitCyc_ff; // device busy
    end
  end

  // bus pins: address set on take, trigger address in setup, strobes only in act
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ceN       <= 1'b1;
      weN       <= 1'b1;
      oeN       <= 1'b1;
      addrLines <= '0;
      dataOut   <= '0;
      dataOeN   <= 1'b1;
    end else begin
      ceN <= !(nxt_state == NVC_ACT); // deselect between cycles
      weN <= !(nxt_state == NVC_ACT && isWrite_ff && !isSeq_ff);
      oeN <= !(nxt_state == NVC_ACT && !isWrite_ff);
      if (state_ff == NVC_IDLE && takeReq && !isNvCmd)
        addrLines <= reqAddr; // held through end
      else if (state_ff == NVC_SETUP && isSeq_ff)
        addrLines <= seqAddr;
      if (state_ff == NVC_IDLE && takeReq)
        dataOut <= reqWdata;
      dataOeN <= !((nxt_state == NVC_SETUP || nxt_state == NVC_ACT
                    || nxt_state == NVC_END) && isWrite_ff && !isSeq_ff
                   && state_ff != NVC_IDLE);
    end
  end

  // request handshake and read capture at end of active window
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspRdata <= '0;
    end else begin
      reqReady <= (nxt_state == NVC_IDLE) && !(state_ff == NVC_IDLE && takeReq);
      rspValid <= 1'b0;
      if (state_ff == NVC_ACT && cntDone && !isWrite_ff && !isSeq_ff) begin
        rspRdata <= dataIn; // sampled after access time
        rspValid <= 1'b1;
      end
      if (state_ff == NVC_WAIT && cntDone) rspValid <= 1'b1;
      if (state_ff == NVC_END && isWrite_ff && !isSeq_ff) rspValid <= 1'b1;
    end
  end

  // strobe relations
  property p_we_excl_oe;
    @(posedge clk) disable iff (!resetn) !weN |-> oeN;
  endproperty
  a_we_excl_oe: assert property (p_we_excl_oe) else $error("oe low during write");
  property p_we_needs_ce;
    @(posedge clk) disable iff (!resetn) !weN |-> !ceN;
  endproperty
  a_we_needs_ce: assert property (p_we_needs_ce) else $error("we without ce");
  property p_seq_no_we;
    @(posedge clk) disable iff (!resetn) (isSeq_ff && !ceN) |-> weN;
  endproperty
  a_seq_no_we: assert property (p_seq_no_we) else $error("write in trigger");
  property p_addr_stable;
    @(posedge clk) disable iff (!resetn) (!ceN && $past(!ceN)) |-> $stable(addrLines);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("addr moved");
  property p_drive_in_write;
    @(posedge clk) disable iff (!resetn) !weN |-> !dataOeN;
  endproperty
  a_drive_in_write: assert property (p_drive_in_write) else $error("no data in write");
  property p_read_float;
    @(posedge clk) disable iff (!resetn) !oeN |-> dataOeN;
  endproperty
  a_read_float: assert property (p_read_float) else $error("contention on read");
  property p_wait_idle;
    @(posedge clk) disable iff (!resetn) (state_ff == NVC_WAIT) |-> ceN && !reqReady;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("access during nv op");
  sequence s_first_seq;
    (state_ff == NVC_SETUP && isSeq_ff && seqIdx_ff == 3'h0) ##1 (state_ff == NVC_ACT);
  endsequence
  property p_seq_first_addr;
    @(posedge clk) disable iff (!resetn) s_first_seq |-> (addrLines == SEQ_A0);
  endproperty
  a_seq_first_addr: assert property (p_seq_first_addr) else $error("bad first addr");
  property p_pwr_block;
    @(posedge clk) disable iff (!resetn) (state_ff == NVC_PWR) |-> ceN && weN;
  endproperty
  a_pwr_block: assert property (p_pwr_block) else $error("access during power up");
  // trigger reads walk the table; the tail picks store or recall
  property p_seq_second_addr;
    @(posedge clk) disable iff (!resetn)
      (state_ff == NVC_ACT && isSeq_ff && seqIdx_ff == 3'h1) |-> (addrLines == SEQ_A1);
  endproperty
  a_seq_second_addr: assert property (p_seq_second_addr) else $error("bad second addr");
  property p_seq_store_tail;
    @(posedge clk) disable iff (!resetn)
      (state_ff == NVC_ACT && isSeq_ff && seqLast && !seqMode_ff) |-> (addrLines == SEQ_STORE);
  endproperty
  a_seq_store_tail: assert property (p_seq_store_tail) else $error("bad store addr");
  property p_seq_recall_tail;
    @(posedge clk) disable iff (!resetn)
      (state_ff == NVC_ACT && isSeq_ff && seqLast && seqMode_ff) |-> (addrLines == SEQ_RECALL);
  endproperty
  a_seq_recall_tail: assert property (p_seq_recall_tail) else $error("bad recall addr");
  // select must rise between trigger reads or the device sees one long read
  property p_ce_gap;
    @(posedge clk) disable iff (!resetn) $rose(ceN) |=> ceN;
  endproperty
  a_ce_gap: assert property (p_ce_gap) else $error("select not released");
  // power-up recall must not be cut short by a stray access
  property p_pwr_hold;
    @(posedge clk) disable iff (!resetn) pwrFirst |=> (state_ff == NVC_PWR) && !reqReady;
  endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("power-up wait skipped");
endmodule // nvc_host

// >>> nvc_host_tb.sv
// self-checking bench for the shadowed sram host controller
`timescale 1ns/100ps
module nvc_host_tb
  import nvc_pkg::*;
;
  logic clk = 1'b0;
  logic resetn;
  logic reqValid;
  logic [1:0] reqCmd;
  logic [ADDR_W-1:0] reqAddr;
  logic [DATA_W-1:0] reqWdata;
  logic reqReady, rspValid, ceN, weN, oeN, dataOeN, dqDrv;
  logic [DATA_W-1:0] rspRdata, dataIn, dataOut, dqOut;
  logic [ADDR_W-1:0] addrLines;
  int failCount = 0;
  int nTests = 0;
  localparam int PWR_SIM = 8;
  always #5 clk = ~clk;
  // shared data lines: host drive wins while its enable is low
  assign dataIn = !dataOeN ? dataOut : dqOut;
  nvc_host #(.STORE_CYCLES(8), .RESTORE_CYCLES(8), .PWRUP_CYCLES(PWR_SIM)) nvc_host_inst (
    .clk(clk), .resetn(resetn), .reqValid(reqValid), .reqCmd(reqCmd),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid),
    .rspRdata(rspRdata), .ceN(ceN), .weN(weN), .oeN(oeN), .addrLines(addrLines),
    .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN));
  nvc_sram_model nvc_sram_model_inst (
    .ceN(ceN), .weN(weN), .oeN(oeN), .addrLines(addrLines), .dqIn(dataIn),
    .dqOut(dqOut), .dqDrv(dqDrv));
  // host and device must never drive the shared data lines together
  always @(negedge clk) begin
    if (resetn === 1'b1)
      check8({7'h00, !dataOeN && dqDrv}, 8'h00, "data line clash");
  end
  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  // one request, held until taken, then wait for its answer
  task automatic access(input logic [1:0] c, input logic [12:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    int n;
    n = 0;
    @(negedge clk);
    reqValid = 1'b1;
    reqCmd = c;
    reqAddr = a;
    reqWdata = d;
    while (reqReady !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      failCount++;
      $display("wrong value at %0t: request not taken", $time);
    end
    @(negedge clk);
    reqValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      failCount++;
      $display("wrong value at %0t: no answer", $time);
    end
    q = rspRdata;
  endtask
  task automatic testPowerUp();
    logic [7:0] q;
    int n;
    n = 0;
    // no request may be taken while the power-up recall runs
    while (reqReady !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check8(8'(n), 8'(PWR_SIM + 2), "power-up wait");
    access(CMD_READ, 13'h0123, 8'h00, q);
    check8(q, 8'h79, "power-up copy");
  endtask
  task automatic testRw();
    logic [7:0] q;
    access(CMD_WRITE, 13'h0000, 8'hC3, q);
    access(CMD_WRITE, 13'h1FFF, 8'h3C, q);
    access(CMD_READ, 13'h0000, 8'h00, q);
    check8(q, 8'hC3, "low address");
    access(CMD_READ, 13'h1FFF, 8'h00, q);
    check8(q, 8'h3C, "high address");
  endtask
  task automatic testStoreRecall();
    logic [7:0] q;
    access(CMD_WRITE, 13'h0123, 8'hA5, q);
    access(CMD_STORE, 13'h0000, 8'h00, q);
    access(CMD_WRITE, 13'h0123, 8'h11, q);
    access(CMD_READ, 13'h0123, 8'h00, q);
    check8(q, 8'h11, "write after store");
    for (int k = 0; k < 2; k++) begin
      access(CMD_RECALL, 13'h0000, 8'h00, q);
      access(CMD_READ, 13'h0123, 8'h00, q);
      check8(q, 8'hA5, "recalled byte");
    end
  endtask
  // plain reads: a write in the middle must kill the trigger
  task automatic testAbort();
    logic [12:0] sq [6] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_STORE};
    logic [7:0] q;
    access(CMD_WRITE, 13'h0123, 8'hB6, q);
    for (int i = 0; i < 6; i++) begin
      if (i == 2) access(CMD_WRITE, 13'h0300, 8'h00, q);
      access(CMD_READ, sq[i], 8'h00, q);
    end
    repeat (10) @(negedge clk);
    access(CMD_RECALL, 13'h0000, 8'h00, q);
    access(CMD_READ, 13'h0123, 8'h00, q);
    check8(q, 8'hA5, "aborted store");
    access(CMD_WRITE, 13'h0123, 8'hD2, q);
    for (int i = 0; i < 6; i++) access(CMD_READ, sq[i], 8'h00, q);
    repeat (10) @(negedge clk);
    access(CMD_WRITE, 13'h0123, 8'h00, q);
    access(CMD_RECALL, 13'h0000, 8'h00, q);
    access(CMD_READ, 13'h0123, 8'h00, q);
    check8(q, 8'hD2, "fresh sequence store");
  endtask
  initial begin
    resetn = 1'b0;
    reqValid = 1'b0;
    reqCmd = CMD_READ;
    reqAddr = 13'h0000;
    reqWdata = 8'h00;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    testPowerUp();
    testRw();
    testStoreRecall();
    testAbort();
    completeRun();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    failCount++;
    $display("wrong value at %0t: watchdog expired", $time);
    completeRun();
  end
endmodule // nvc_host_tb

// >>> nvc_pkg.sv
// package for the shadowed sram host controller
package nvc_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int SEQ_LEN = 6;
  // trigger sequence addresses
  localparam logic [12:0] SEQ_A0 = 13'h0000;
  localparam logic [12:0] SEQ_A1 = 13'h1555;
  localparam logic [12:0] SEQ_A2 = 13'h0AAA;
  localparam logic [12:0] SEQ_A3 = 13'h1FFF;
  localparam logic [12:0] SEQ_A4 = 13'h10F0;
  localparam logic [12:0] SEQ_STORE = 13'h0F0F;
  localparam logic [12:0] SEQ_RECALL = 13'h0F0E;
  // timing in ns at 100 MHz
  localparam int CLK_NS = 10;
  localparam int ACCESS_NS = 50;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int STORE_NS = 10_000_000;
  localparam int STORE_CYC = (STORE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESTORE_NS = 20_000;
  localparam int RESTORE_CYC = (RESTORE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_NS = 550_000;
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 24;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_STORE = 2'h2;
  localparam logic [1:0] CMD_RECALL = 2'h3;
  typedef enum logic [2:0] {
    NVC_IDLE  = 3'b000,
    NVC_SETUP = 3'b001,
    NVC_ACT   = 3'b010,
    NVC_END   = 3'b011,
    NVC_WAIT  = 3'b100,
    NVC_PWR   = 3'b101
  } nvc_state_t;
endpackage

// >>> nvc_seq_rom.sv
// trigger address sequencer table with registered output
`timescale 1ns/100ps
module nvc_seq_rom
  import nvc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [2:0]        idx,
  input  wire logic              recall,
  output logic      [ADDR_W-1:0] addrOut
);
  logic [ADDR_W-1:0] nxt_addr;
  // last entry chooses store or recall target
  always_comb begin
    case (idx)
      3'h0: nxt_addr = SEQ_A0;
      3'h1: nxt_addr = SEQ_A1;
      3'h2: nxt_addr = SEQ_A2;
      3'h3: nxt_addr = SEQ_A3;
      3'h4: nxt_addr = SEQ_A4;
      default: nxt_addr = recall ? SEQ_RECALL : SEQ_STORE;
    endcase
  end
  // registered read data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addrOut <= '0;
    end else begin
      addrOut <= nxt_addr;
    end
  end
endmodule // nvc_seq_rom

// >>> nvc_sram_model.sv
// behavioural shadowed sram as seen from the host pins
`timescale 1ns/100ps
module nvc_sram_model
  import nvc_pkg::*;
#(
  parameter int BUSY_NS = 40
) (
  input  wire logic              ceN,
  input  wire logic              weN,
  input  wire logic              oeN,
  input  wire logic [ADDR_W-1:0] addrLines,
  input  wire logic [DATA_W-1:0] dqIn,
  output logic      [DATA_W-1:0] dqOut,
  output logic                   dqDrv
);
  logic [DATA_W-1:0] sram [0:8191];
  logic [DATA_W-1:0] nv   [0:8191];
  logic              busy;
  logic              sawWr = 1'b0;
  int                seqPos = 0;
  logic [ADDR_W-1:0] expA;
  wire               wrAct = !ceN && !weN && !busy;
  // released lines show the inverse byte, so a late sample cannot pass
  assign dqDrv = !ceN && !oeN && weN && !busy;
  assign dqOut = dqDrv ? sram[addrLines] : ~sram[addrLines];
  assign expA = (seqPos == 0) ? SEQ_A0 : (seqPos == 1) ? SEQ_A1 :
                (seqPos == 2) ? SEQ_A2 : (seqPos == 3) ? SEQ_A3 : SEQ_A4;
  // copy between arrays; pins are dead meanwhile
  task automatic nvOp(input bit toNv);
    busy = 1'b1;
    #(BUSY_NS);
    for (int i = 0; i < 8192; i++) begin
      if (toNv) nv[i] = sram[i];
      else sram[i] = nv[i];
    end
    busy = 1'b0;
  endtask
  // power-up recall from a known pattern
  initial begin
    busy = 1'b1;
    for (int i = 0; i < 8192; i++) nv[i] = 8'(i) ^ 8'h5A;
    nvOp(1'b0);
  end
  // byte lands when the write cycle ends
  always @(negedge wrAct) sram[addrLines] <= dqIn;
  always @(posedge wrAct) sawWr <= 1'b1;
  // select-timed reads walk the trigger detector
  always @(posedge ceN) begin
    if (!busy) begin
      if (sawWr) seqPos = 0;
      else if (seqPos == 5 && addrLines == SEQ_STORE) begin
        seqPos = 0;
        nvOp(1'b1);
      end else if (seqPos == 5 && addrLines == SEQ_RECALL) begin
        seqPos = 0;
        nvOp(1'b0);
      end else if (seqPos < 5 && addrLines == expA) seqPos = seqPos + 1;
      else seqPos = (addrLines == SEQ_A0) ? 1 : 0;
      sawWr <= 1'b0;
    end
  end
endmodule // nvc_sram_model
